// [hdl/osdreg_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module osdreg_regs #(
   parameter int CHAR_PIX = 12
) (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rstn_i,
   // External data space access
   input  wire osdreg_pkg::osdreg_xreq_t xreq_i,
   output logic [7:0]                    xrdata_o,
   // Display timing from the raster logic
   input  wire logic                     hsync_i,
   input  wire logic                     vsync_i,
   input  wire logic                     field_even_i,
   input  wire logic                     h_active_i,
   input  wire logic                     v_active_i,
   input  wire logic                     rgb_active_i,
   input  wire logic [5:0]               char_col_i,
   // Configuration and derived timing
   output osdreg_pkg::osdreg_cfg_t       cfg_o,
   output logic                          pix_en_o,
   output logic                          hsync_ref_o,
   output logic                          vsync_ref_o,
   output logic                          vstart_o,
   output logic                          text_area_o,
   output logic                          rgb_en_o,
   output logic                          vds_o
);

   // -------------------------------------------------------------
   // Register file
   // -------------------------------------------------------------
   logic [7:0] regs_q [osdreg_pkg::NUM_REGS];
   logic [7:0] xrdata_q;

   wire        hit_w = (xreq_i.addr[15:4] == osdreg_pkg::REG_BASE[15:4]);
   wire  [3:0] idx_w = xreq_i.addr[3:0];
   wire        wr_w  = xreq_i.wr & hit_w;
   wire        rd_w  = xreq_i.rd & hit_w;

   wire        busy_axis_select = regs_q[osdreg_pkg::IDX_CONFIG][3];
   // Busy follows the chosen scan axis
   wire        busy_w = busy_axis_select ? h_active_i : v_active_i; // RULE_21
   wire  [7:0] status_w = {busy_w, field_even_i,                   // RULE_10 RULE_11
                           regs_q[osdreg_pkg::IDX_STATUS][5:0]};     // RULE_12
   wire  [7:0] rd_mux_w = (idx_w == osdreg_pkg::IDX_STATUS) ? status_w : regs_q[idx_w];

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < osdreg_pkg::NUM_REGS; i++) begin
            regs_q[i] <= osdreg_pkg::REG_RESET;
         end
      end else if (wr_w) begin
         regs_q[idx_w] <= xreq_i.wdata & osdreg_pkg::WR_MASK[idx_w]; // RULE_20
      end
   end

   // Reads outside the window answer zero so a shared bus sees no junk
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         xrdata_q <= 8'h00;
      end else if (xreq_i.rd) begin
         xrdata_q <= rd_w ? rd_mux_w : 8'h00; // RULE_20
      end
   end

   assign xrdata_o = xrdata_q;

   // -------------------------------------------------------------
   // Field views
   // -------------------------------------------------------------
   wire [7:0] r_disp  = regs_q[osdreg_pkg::IDX_DISP];
   wire [7:0] r_vpos  = regs_q[osdreg_pkg::IDX_VPOS];
   wire [7:0] r_ast   = regs_q[osdreg_pkg::IDX_ASTART];
   wire [7:0] r_fr    = regs_q[osdreg_pkg::IDX_FRINGE];
   wire [7:0] r_aend  = regs_q[osdreg_pkg::IDX_AEND];
   wire [7:0] r_rarea = regs_q[osdreg_pkg::IDX_RAREA];
   wire [7:0] r_rrng  = regs_q[osdreg_pkg::IDX_RRANGE];
   wire [7:0] r_lvl   = regs_q[osdreg_pkg::IDX_LEVEL];
   wire [7:0] r_stat  = regs_q[osdreg_pkg::IDX_STATUS];
   wire [7:0] r_hsd   = regs_q[osdreg_pkg::IDX_HSD];
   wire [7:0] r_vsd   = regs_q[osdreg_pkg::IDX_VSD];
   wire [7:0] r_rtop  = regs_q[osdreg_pkg::IDX_RTOP];
   wire [7:0] r_cfg   = regs_q[osdreg_pkg::IDX_CONFIG];

   wire       switch_polarity = r_lvl[7];
   wire [2:0] switch_skew     = r_cfg[6:4];
   wire       roll_enable     = r_stat[5];

   osdreg_pkg::osdreg_cfg_t cfg_d;
   osdreg_pkg::osdreg_cfg_t cfg_q;

   always_comb begin
      cfg_d                        = '0;
      cfg_d.screen_mix_select      = osdreg_pkg::osdreg_mix_t'(r_disp[1:0]); // RULE_01
      cfg_d.screen_colour          = r_disp[7:4];                           // RULE_22
      cfg_d.background_mesh        = r_disp[2];                             // RULE_02
      cfg_d.vertical_start_offset  = r_vpos[5:0];                           // RULE_04
      cfg_d.fine_horizontal_offset = r_ast[7:6];                            // RULE_05
      cfg_d.text_area_start        = r_ast[5:0];                            // RULE_06
      cfg_d.text_area_end          = r_aend[5:0];                           // RULE_06
      cfg_d.fringe_colour          = r_fr[7:4];                             // RULE_07
      cfg_d.fringe_nesw            = r_fr[3:0];                             // RULE_08
      cfg_d.roll_enable            = roll_enable;                           // RULE_09
      // Roll geometry except roll_top_line is masked while rolling is off so no stale area shows
      cfg_d.soft_roll_height       = roll_enable ? r_rarea[7:4] : 4'h0;     // RULE_09
      cfg_d.soft_roll_position     = roll_enable ? r_rarea[3:0] : 4'h0;     // RULE_09
      cfg_d.roll_stop_row          = roll_enable ? r_rrng[7:4] : 4'h0;      // RULE_09
      cfg_d.roll_start_row         = roll_enable ? r_rrng[3:0] : 4'h0;      // RULE_09
      cfg_d.leading_row_index      = roll_enable ? r_stat[3:0] : 4'h0;      // RULE_09
      cfg_d.roll_top_line          = r_rtop[3:0];
      cfg_d.flash_region_backdrop  = r_stat[4];                             // RULE_12
      cfg_d.rgb_level              = r_lvl[3:0];                            // RULE_19
      cfg_d.closed_caption_select  = r_cfg[7];                              // RULE_15
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cfg_q <= '0;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   assign cfg_o = cfg_q;

   // -------------------------------------------------------------
   // Pixel rate enable
   // -------------------------------------------------------------
   // Integer divide of the system clock; exact line lock lives outside
   logic [1:0] pix_cnt_q;
   logic       pix_en_q;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pix_cnt_q <= 2'h0;
         pix_en_q  <= 1'b0;
      end else begin
         pix_en_q  <= (pix_cnt_q == osdreg_pkg::PIX_DIV_LAST);
         pix_cnt_q <= (pix_cnt_q == osdreg_pkg::PIX_DIV_LAST) ? 2'h0 : pix_cnt_q + 2'h1;
      end
   end

   assign pix_en_o = pix_en_q;

   // -------------------------------------------------------------
   // Sync polarity and delay, channel 0 horizontal, 1 vertical
   // -------------------------------------------------------------
   wire [1:0]  sync_in_w  = {vsync_i, hsync_i};
   wire [1:0]  sync_inv_w = {r_vpos[7], r_vpos[6]};
   wire [10:0] sync_load_w [2];
   wire [1:0]  sync_edge_w;
   wire [1:0]  sync_ref_w;

   assign sync_load_w[0] = 11'(int'(r_hsd[6:0]) * CHAR_PIX);               // RULE_13
   assign sync_load_w[1] = 11'(int'(r_vsd[6:0]) * osdreg_pkg::VSYNC_UNIT); // RULE_14

   for (genvar g = 0; g < 2; g++) begin : g_sync
      logic        prev_q;
      logic        pend_q;
      logic        ref_q;
      logic [10:0] cnt_q;
      wire         lvl_w = sync_in_w[g] ^ sync_inv_w[g]; // RULE_03

      assign sync_edge_w[g] = lvl_w & ~prev_q;
      assign sync_ref_w[g]  = ref_q;

      // A new edge restarts the delay; the older one is dropped
      always_ff @(posedge clk_i) begin
         if (!rstn_i) begin
            prev_q <= 1'b0;
            pend_q <= 1'b0;
            ref_q  <= 1'b0;
            cnt_q  <= 11'h000;
         end else begin
            prev_q <= lvl_w;
            ref_q  <= 1'b0;
            if (sync_edge_w[g]) begin
               cnt_q  <= sync_load_w[g];
               pend_q <= 1'b1;
            end else if (pix_en_q && pend_q) begin
               if (cnt_q == 11'h000) begin
                  ref_q  <= 1'b1;
                  pend_q <= 1'b0;
               end else begin
                  cnt_q <= cnt_q - 11'h001;
               end
            end
         end
      end
   end

   assign hsync_ref_o = sync_ref_w[0];
   assign vsync_ref_o = sync_ref_w[1];

   // -------------------------------------------------------------
   // Vertical start and text area
   // -------------------------------------------------------------
   logic [5:0] line_cnt_q;
   logic       vstart_q;
   logic       text_area_q;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         line_cnt_q <= 6'h00;
         vstart_q   <= 1'b0;
      end else if (sync_ref_w[1]) begin
         line_cnt_q <= 6'h00;
         vstart_q   <= 1'b0;
      end else if (sync_ref_w[0]) begin
         if (line_cnt_q == r_vpos[5:0]) begin
            vstart_q <= 1'b1; // RULE_04
         end
         if (line_cnt_q != 6'h3f) begin
            line_cnt_q <= line_cnt_q + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         text_area_q <= 1'b0;
      end else begin
         text_area_q <= (char_col_i >= r_ast[5:0]) && (char_col_i <= r_aend[5:0]); // RULE_06
      end
   end

   assign vstart_o    = vstart_q;
   assign text_area_o = text_area_q;

   // -------------------------------------------------------------
   // Video/data switch alignment
   // -------------------------------------------------------------
   // RGB leaves from the middle tap so the switch can lead or lag it
   logic [2:0] pix_pipe_q;
   logic       rgb_en_q;
   logic       vds_q;
   logic       vds_act_w;

   always_comb begin
      case (switch_skew)
         osdreg_pkg::SKEW_EARLY: vds_act_w = pix_pipe_q[0]; // RULE_17
         osdreg_pkg::SKEW_SYNC:  vds_act_w = pix_pipe_q[1]; // RULE_17
         osdreg_pkg::SKEW_LATE:  vds_act_w = pix_pipe_q[2]; // RULE_17
         default:                vds_act_w = 1'b0;          // RULE_16
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pix_pipe_q <= 3'h0;
         rgb_en_q   <= 1'b0;
         vds_q      <= 1'b0;
      end else begin
         if (pix_en_q) begin
            pix_pipe_q <= {pix_pipe_q[1:0], rgb_active_i};
         end
         rgb_en_q <= pix_pipe_q[1];
         vds_q    <= vds_act_w ^ switch_polarity; // RULE_18
      end
   end

   assign rgb_en_o = rgb_en_q;
   assign vds_o    = vds_q;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   a_status_busy: assert property ( // RULE_10
      rd_w && idx_w == osdreg_pkg::IDX_STATUS |=> xrdata_o[7] == $past(busy_w))
      else $error("busy bit wrong in status read");

   a_field_read: assert property ( // RULE_11
      rd_w && idx_w == osdreg_pkg::IDX_STATUS |=> xrdata_o[6] == $past(field_even_i))
      else $error("field bit wrong in status read");

   a_reserved_zero: assert property ( // RULE_20
      xreq_i.rd && (!hit_w || idx_w == 4'h9 || idx_w == 4'ha || idx_w == 4'hb)
      |=> xrdata_o == 8'h00)
      else $error("reserved or unmapped read not zero");

   a_mode_decode: assert property ( // RULE_01
      wr_w && idx_w == osdreg_pkg::IDX_DISP ##1 !(wr_w && idx_w == osdreg_pkg::IDX_DISP)
      |=> cfg_o.screen_mix_select == $past(xreq_i.wdata[1:0], 2))
      else $error("mix select not taken from write");

   a_vds_idle: assert property ( // RULE_16
      switch_skew == osdreg_pkg::SKEW_OFF |=> vds_o == $past(switch_polarity))
      else $error("switch left video level with skew off");

   a_vds_sync: assert property ( // RULE_17
      switch_skew == osdreg_pkg::SKEW_SYNC |=> vds_o == (rgb_en_o ^ $past(switch_polarity)))
      else $error("coincident switch not aligned to RGB");

   a_hsync_delay: assert property ( // RULE_13
      sync_edge_w[0] && r_hsd[6:0] == 7'h00 ##1 !sync_edge_w[0] [*4]
      |-> (hsync_ref_o || $past(hsync_ref_o) || $past(hsync_ref_o, 2)) or ##1 hsync_ref_o)
      else $error("zero hsync delay did not fire");

   a_vsync_invert: assert property ( // RULE_03
      sync_edge_w[1] |-> (vsync_i ^ r_vpos[7]) && !$past(vsync_i ^ r_vpos[7]))
      else $error("vsync edge ignores polarity");

   a_vstart_line: assert property ( // RULE_04
      $rose(vstart_o) |-> $past(line_cnt_q) == $past(r_vpos[5:0]) && $past(hsync_ref_o))
      else $error("display start on wrong line");

   c_status_read: cover property (rd_w && idx_w == osdreg_pkg::IDX_STATUS);
   c_vds_early: cover property (switch_skew == osdreg_pkg::SKEW_EARLY && $rose(vds_o));
   c_vstart: cover property ($rose(vstart_o));
   c_vsync_ref: cover property (vsync_ref_o && r_vsd[6:0] != 7'h00);

endmodule
`default_nettype wire

// [hdl/osdreg_pkg.sv]
// Functional notes
// (RULE_01) Mix select codes: video, full text, mixed screen colour, mixed video.
// (RULE_02) Mesh bit meshes all background colours of displayed text.
// (RULE_03) Sync invert bits flip incoming vertical or horizontal sync before use.
// (RULE_04) Display starts a programmed number of lines after vertical sync.
// (RULE_05) Text shifted horizontally in quarter-character steps.
// (RULE_06) Text area bounded by start and end fields, end in whole characters.
// (RULE_07) Fringe colour is a colour lookup table entry address.
// (RULE_08) Fringe drawn only on sides whose direction bit is set.
// (RULE_09) Roll enable turns on soft-roll area with its bounds and offsets.
// (RULE_10) Busy status reads one when memory access could disturb picture.
// (RULE_11) Field status reads one in even field, zero in odd field.
// (RULE_12) Flash backdrop bit shows background only; writable, readable in status.
// (RULE_13) Horizontal sync reference delayed in full character widths.
// (RULE_14) Vertical sync reference delayed in units of eight display clocks.
// (RULE_15) Closed-caption select runs caption mode instead of teletext mode.
// (RULE_16) Skew code zero holds switch output at video level, never active.
// (RULE_17) Skew codes one, two, four: switch early, coincident, late by one pixel.
// (RULE_18) Switch polarity zero: RGB high, video low; one reverses levels.
// (RULE_19) Four-bit level field sets RGB high level, lowest to highest.
// (RULE_20) Sixteen registers at consecutive external data addresses.
// (RULE_21) Busy axis select one follows horizontal, zero vertical activity.
// (RULE_22) Screen colour field picks colour outside the text area.
package osdreg_pkg;

   // -------------------------------------------------------------
   // Address map
   // -------------------------------------------------------------
   localparam logic [15:0] REG_BASE   = 16'h87f0;
   localparam int          NUM_REGS   = 16;
   localparam logic [3:0]  IDX_DISP   = 4'h0;
   localparam logic [3:0]  IDX_VPOS   = 4'h1;
   localparam logic [3:0]  IDX_ASTART = 4'h2;
   localparam logic [3:0]  IDX_FRINGE = 4'h3;
   localparam logic [3:0]  IDX_AEND   = 4'h4;
   localparam logic [3:0]  IDX_RAREA  = 4'h5;
   localparam logic [3:0]  IDX_RRANGE = 4'h6;
   localparam logic [3:0]  IDX_LEVEL  = 4'h7;
   localparam logic [3:0]  IDX_STATUS = 4'h8;
   localparam logic [3:0]  IDX_HSD    = 4'hc;
   localparam logic [3:0]  IDX_VSD    = 4'hd;
   localparam logic [3:0]  IDX_RTOP   = 4'he;
   localparam logic [3:0]  IDX_CONFIG = 4'hf;
   localparam logic [7:0]  REG_RESET  = 8'h00;

   // Writable bits per register; reserved bits and registers stay zero
   localparam logic [7:0] WR_MASK [NUM_REGS] = '{
      8'hf7, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h8f,
      8'h3f, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h7f, 8'h0f, 8'hf8};

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int         CLK_HZ        = 50_000_000;
   localparam int         PIX_HZ        = 12_000_000;
   localparam int         PIX_DIV       = CLK_HZ / PIX_HZ;
   localparam logic [1:0] PIX_DIV_LAST  = 2'(PIX_DIV - 1);
   localparam int         VSYNC_UNIT    = 8;
   localparam logic [2:0] SKEW_OFF      = 3'h0;
   localparam logic [2:0] SKEW_EARLY    = 3'h1;
   localparam logic [2:0] SKEW_SYNC     = 3'h2;
   localparam logic [2:0] SKEW_LATE     = 3'h4;

   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      MIX_VIDEO      = 2'h0,
      MIX_FULL_TEXT  = 2'h1,
      MIX_SCREEN     = 2'h2,
      MIX_OVER_VIDEO = 2'h3
   } osdreg_mix_t;

   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } osdreg_xreq_t;

   typedef struct packed {
      osdreg_mix_t screen_mix_select;
      logic [3:0]  screen_colour;
      logic        background_mesh;
      logic [5:0]  vertical_start_offset;
      logic [1:0]  fine_horizontal_offset;
      logic [5:0]  text_area_start;
      logic [5:0]  text_area_end;
      logic [3:0]  fringe_colour;
      logic [3:0]  fringe_nesw;
      logic        roll_enable;
      logic [3:0]  soft_roll_height;
      logic [3:0]  soft_roll_position;
      logic [3:0]  roll_start_row;
      logic [3:0]  roll_stop_row;
      logic [3:0]  leading_row_index;
      logic [3:0]  roll_top_line;
      logic        flash_region_backdrop;
      logic [3:0]  rgb_level;
      logic        closed_caption_select;
   } osdreg_cfg_t;

endpackage

// [tb/osdreg_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module osdreg_core_model (
   // Bus side
   input  wire logic                [7:0] xrdata_i,
   input  wire logic                      clk_i,
   output osdreg_pkg::osdreg_xreq_t       xreq_o
);
   // ----------
   // Bus cycles
   // ----------
   initial xreq_o = '{addr: 16'h0000, wr: 1'b0, rd: 1'b0, wdata: 8'h00};

   // Idle bus shows inverted leftovers so a stale value never passes
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      xreq_o <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk_i);
      xreq_o <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_i);
      xreq_o <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clk_i);
      xreq_o <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'h5a};
      #1;
      d = xrdata_i;
   endtask
endmodule
`default_nettype wire

// [tb/osd_display_control_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module osd_display_control_regs_tb;
   // ----------
   // Signals
   // ----------
   logic                     clk_i, rstn_i, hsync_i, vsync_i, field_even_i;
   logic                     h_active_i, v_active_i, rgb_active_i;
   logic                     pix_en_o, hsync_ref_o, vsync_ref_o, vstart_o;
   logic                     text_area_o, rgb_en_o, vds_o;
   logic [5:0]               char_col_i;
   logic [7:0]               xrdata_o;
   osdreg_pkg::osdreg_xreq_t xreq_i;
   osdreg_pkg::osdreg_cfg_t  cfg_o;
   int                       err_count, tests_run, n0, n1, na, nb;
   localparam logic [15:0]   base = osdreg_pkg::REG_BASE;

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // Short character keeps the horizontal sync delay cheap to run
   osdreg_regs #(.CHAR_PIX(2)) osdreg_regs_i (
      .clk_i(clk_i), .rstn_i(rstn_i), .xreq_i(xreq_i), .xrdata_o(xrdata_o),
      .hsync_i(hsync_i), .vsync_i(vsync_i), .field_even_i(field_even_i),
      .h_active_i(h_active_i), .v_active_i(v_active_i), .rgb_active_i(rgb_active_i),
      .char_col_i(char_col_i), .cfg_o(cfg_o), .pix_en_o(pix_en_o),
      .hsync_ref_o(hsync_ref_o), .vsync_ref_o(vsync_ref_o), .vstart_o(vstart_o),
      .text_area_o(text_area_o), .rgb_en_o(rgb_en_o), .vds_o(vds_o));

   osdreg_core_model osdreg_core_model_i (
      .xrdata_i(xrdata_o), .clk_i(clk_i), .xreq_o(xreq_i));

   // ----------
   // Helpers
   // ----------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic w(input logic [3:0] i, input logic [7:0] d);
      osdreg_core_model_i.wr(base + 16'(i), d);
   endtask

   task automatic rc(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      osdreg_core_model_i.rd(a, d);
      check(d, e);
   endtask

   task automatic settle();
      repeat (3) @(posedge clk_i);
      #1;
   endtask

   function automatic logic [7:0] inr(input int v, input int lo, input int hi);
      return {7'h00, v >= lo && v <= hi};
   endfunction

   function automatic logic sel(input int k);
      case (k)
         0: return hsync_ref_o;
         1: return vsync_ref_o;
         2: return rgb_en_o;
         3: return vds_o;
         default: return vstart_o;
      endcase
   endfunction

   // Bounded wait; a timeout ends the run as a failure
   task automatic wait_for(input int k, output int n);
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
         if (n > 300) begin
            err_count++;
            test_done();
         end
      end while (sel(k) !== 1'b1);
   endtask

   task automatic vds_lat(input logic [2:0] skew, output int d);
      w(4'hf, {1'b0, skew, 4'h0});
      @(posedge clk_i);
      rgb_active_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      rgb_active_i <= 1'b1;
      fork
         wait_for(2, na);
         wait_for(3, nb);
      join
      d = nb - na;
   endtask

   // ----------
   // Sequence
   // ----------
   initial begin
      {rstn_i, hsync_i, vsync_i, field_even_i} = 4'h0;
      {h_active_i, v_active_i, rgb_active_i} = 3'h0;
      char_col_i = 6'h00;
      err_count = 0;
      tests_run = 0;
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      for (int i = 0; i < 16; i++) rc(base + 16'(i), osdreg_pkg::REG_RESET);
      osdreg_core_model_i.wr(16'h87e5, 8'hff);
      rc(16'h87e5, 8'h00);
      rc(base + 16'h0005, 8'h00);
      for (int i = 0; i < 16; i++) w(4'(i), 8'hff);
      for (int i = 0; i < 16; i++) begin
         rc(base + 16'(i), i == 8 ? 8'h3f : osdreg_pkg::WR_MASK[i]);
      end
      settle();
      check(8'(cfg_o.soft_roll_height), 8'h0f);
      check(8'(cfg_o.flash_region_backdrop), 8'h01);
      check(8'(cfg_o.soft_roll_position), 8'h0f);
      check(8'(cfg_o.roll_start_row), 8'h0f);
      check(8'(cfg_o.roll_top_line), 8'h0f);
      w(4'h8, 8'h05);
      settle();
      check(8'(cfg_o.soft_roll_height), 8'h00);
      check(8'(cfg_o.leading_row_index), 8'h00);
      w(4'h8, 8'h25);
      settle();
      check(8'(cfg_o.leading_row_index), 8'h05);
      @(posedge clk_i);
      field_even_i <= 1'b1;
      h_active_i <= 1'b1;
      rc(base + 16'h0008, 8'he5);
      w(4'hf, 8'h80);
      rc(base + 16'h0008, 8'h65);
      check(8'(cfg_o.closed_caption_select), 8'h01);
      for (int m = 0; m < 4; m++) begin
         w(4'h0, 8'ha4 | 8'(m));
         settle();
         check(8'(cfg_o.screen_mix_select), 8'(m));
         check(8'(cfg_o.screen_colour), 8'h0a);
         check(8'(cfg_o.background_mesh), 8'h01);
      end
      w(4'h3, 8'h5a);
      w(4'h2, 8'h82);
      w(4'h4, 8'h05);
      w(4'h7, 8'h0c);
      settle();
      check(8'(cfg_o.fringe_colour), 8'h05);
      check(8'(cfg_o.fringe_nesw), 8'h0a);
      check(8'(cfg_o.fine_horizontal_offset), 8'h02);
      check(8'(cfg_o.rgb_level), 8'h0c);
      for (int c = 1; c < 8; c++) begin
         @(posedge clk_i);
         char_col_i <= 6'(c);
         settle();
         check(8'(text_area_o), inr(c, 2, 5));
      end
      // Pending delays from the sweep must drain before timing syncs
      w(4'h1, 8'h00);
      w(4'hc, 8'h00);
      w(4'hd, 8'h00);
      repeat (1100) @(posedge clk_i);
      hsync_i <= 1'b1;
      wait_for(0, n0);
      @(posedge clk_i);
      hsync_i <= 1'b0;
      w(4'hc, 8'h03);
      @(posedge clk_i);
      hsync_i <= 1'b1;
      wait_for(0, n1);
      check(inr(n1 - n0, 21, 27), 8'h01);
      w(4'hc, 8'h00);
      w(4'h1, 8'h40);
      @(posedge clk_i);
      hsync_i <= 1'b0;
      wait_for(0, n0);
      check(inr(n0, 1, 8), 8'h01);
      @(posedge clk_i);
      vsync_i <= 1'b1;
      wait_for(1, n0);
      @(posedge clk_i);
      vsync_i <= 1'b0;
      w(4'hd, 8'h02);
      @(posedge clk_i);
      vsync_i <= 1'b1;
      wait_for(1, n1);
      check(inr(n1 - n0, 61, 67), 8'h01);
      settle();
      check(8'(vstart_o), 8'h00);
      @(posedge clk_i);
      hsync_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      hsync_i <= 1'b0;
      wait_for(4, n0);
      check(inr(n0, 1, 12), 8'h01);
      for (int k = 0; k < 3; k++) begin
         vds_lat(3'(1 << k), n0);
         check(8'(n0 + 2 * osdreg_pkg::PIX_DIV), 8'(osdreg_pkg::PIX_DIV * (k + 1)));
      end
      w(4'h7, 8'h8c);
      settle();
      check(8'(vds_o), 8'h00);
      @(posedge clk_i);
      rgb_active_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      check(8'(vds_o), 8'h01);
      w(4'hf, 8'h00);
      rgb_active_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      check(8'(vds_o), 8'h01);
      w(4'h7, 8'h0c);
      settle();
      check(8'(vds_o), 8'h00);
      check(8'(rgb_en_o), 8'h01);
      test_done();
   end
endmodule
`default_nettype wire
